// file: tc_pair_pkg.sv
package tc_pair_pkg;

    localparam int          ADDR_W        = 20;
    localparam int          DATA_W        = 8;

    localparam logic [19:0] CMP0_OFS      = 20'h00026;
    localparam logic [19:0] CMP1_OFS      = 20'h00027;
    localparam logic [19:0] PWM_OUTPUT_PIN_OFS      = 20'h00028;
    localparam logic [19:0] PWM1_OFS      = 20'h00029;
    localparam logic [19:0] MODE0_OFS     = 20'h0002A;
    localparam logic [19:0] MODE1_OFS     = 20'h0002B;
    localparam logic [19:0] CTRL_OFS      = 20'h0002C;
    localparam logic [19:0] SYSM_OFS      = 20'h0002D;
    localparam logic [19:0] CNT0_OFS      = 20'h0002E;
    localparam logic [19:0] CNT1_OFS      = 20'h0002F;

    localparam logic [7:0]  VALUE_RST     = 8'hFF;
    localparam logic [7:0]  MODE_RST      = 8'hC0;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  SYSM_RST      = 8'h00;
    localparam logic [7:0]  CNT_RST       = 8'h00;
    localparam logic [7:0]  CNT_TOP       = 8'hFF;

    // mode register fields
    localparam int          TFF_BIT       = 7;
    localparam int          DBE_BIT       = 6;
    localparam int          CKS_LSB       = 3;
    localparam int          EXT_BIT       = 2;
    localparam int          OPM_LSB       = 0;

    // pair control and system mode fields
    localparam int          RUN_LO_BIT    = 0;
    localparam int          RUN_HI_BIT    = 1;
    localparam int          CAS_BIT       = 2;
    localparam int          PRESC_BIT     = 0;
    localparam int          SLOW_BIT      = 1;

    // gear prescaler covers divide by 2^11, low-frequency one by 2^4
    localparam int          PRE_W         = 11;
    localparam int          FS_W          = 4;

    typedef enum logic [1:0] {
        OPM_TIMER_A = 2'b00,
        OPM_TIMER_B = 2'b01,
        OPM_PWM     = 2'b10,
        OPM_PPG     = 2'b11
    } opmode_t;

endpackage : tc_pair_pkg

// file: chan_if.sv
`timescale 1ns/10ps
interface chan_if;
    logic       tick;
    logic       run;
    logic       clr;
    logic [7:0] cnt;
    logic       carry;
    modport ctrl (output tick, output run, output clr,
                  input cnt, input carry);
    modport chan (input tick, input run, input clr,
                  output cnt, output carry);
endinterface : chan_if

// file: tc_counter.sv
`timescale 1ns/10ps
module tc_counter (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    chan_if.chan      ch
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    assign cnt_next = ch.clr ? tc_pair_pkg::CNT_RST :
                      (ch.run && ch.tick) ? 8'(cnt_reg + 8'h01) :
                      cnt_reg;
    assign ch.cnt   = cnt_reg;
    assign ch.carry = ch.run && ch.tick && (cnt_reg == tc_pair_pkg::CNT_TOP);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= tc_pair_pkg::CNT_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    property p_clear_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        ch.clr |=> (cnt_reg == tc_pair_pkg::CNT_RST);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("counter not zero after clear");

endmodule : tc_counter

// file: tc_pair_top.sv
`timescale 1ns/10ps
module tc_pair_top (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    input  wire logic [1:0]  event_input_pin,
    input  wire logic        low_frequency_clock,
    output logic      [1:0]  pwm_output_pin,
    output logic      [1:0]  pulse_output_pin
);
    logic                          rst_s1_reg;
    logic                          rst_n_reg;
    logic [tc_pair_pkg::PRE_W-1:0] pre_reg;
    logic [tc_pair_pkg::FS_W-1:0]  fs_cnt_reg;
    logic                          fs_s1_reg;
    logic                          fs_s2_reg;
    logic                          fs_s3_reg;
    logic [1:0]                    ev_s1_reg;
    logic [1:0]                    ev_s2_reg;
    logic [1:0]                    ev_s3_reg;
    logic [7:0]                    ctrl_reg;
    logic [7:0]                    sysm_reg;
    logic [7:0]                    rdata_reg;
    logic [7:0]                    rd_val;
    logic [7:0]                    cmp_reg   [2];
    logic [7:0]                    pwm_reg   [2];
    logic [7:0]                    mode_reg  [2];
    logic [7:0]                    eff_mode  [2];
    logic [7:0]                    cnt_w     [2];
    logic [7:0]                    cmp_act   [2];
    logic [1:0]                    run_w;
    logic [1:0]                    tick_w;
    logic [1:0]                    carry_w;
    logic [1:0]                    clr_w;
    logic [1:0]                    m8_w;
    logic [1:0]                    pm8_w;
    logic [1:0]                    ev_fall;
    logic                          cascade;
    logic                          fs_rise;
    logic                          m16_w;
    logic                          pm16_w;
    logic                          presc;
    logic                          slow;

    // clock select: event pin wins, then low-frequency codes, then gear taps
    function automatic logic sel_tick(
        input logic [7:0]                    m,
        input logic                          ext_fall,
        input logic                          presc_i,
        input logic                          slow_i,
        input logic [tc_pair_pkg::PRE_W-1:0] pre,
        input logic                          fs_r,
        input logic [tc_pair_pkg::FS_W-1:0]  fsc
    );
        logic [2:0] c;
        logic       t;
        c = m[tc_pair_pkg::CKS_LSB +: 3];
        t = 1'b0;
        if (m[tc_pair_pkg::EXT_BIT]) begin
            t = ext_fall;
        end else if ((presc_i || slow_i) && c == 3'h0) begin
            t = fs_r && (&fsc[3:0]);
        end else if ((presc_i || slow_i) && c == 3'h1) begin
            t = fs_r && (&fsc[2:0]);
        end else if (slow_i) begin
            t = (c == 3'h7) && fs_r && (&fsc[1:0]);
        end else begin
            case (c)
                3'h0:    t = &pre[10:0];
                3'h1:    t = &pre[9:0];
                3'h2:    t = &pre[7:0];
                3'h3:    t = &pre[5:0];
                3'h4:    t = &pre[3:0];
                3'h5:    t = &pre[1:0];
                3'h6:    t = pre[0];
                default: t = 1'b1;
            endcase
        end
        return t;
    endfunction : sel_tick

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // pins are asynchronous; first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ev_s1_reg <= 2'h3;
            ev_s2_reg <= 2'h3;
            ev_s3_reg <= 2'h3;
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            fs_s3_reg <= 1'b0;
        end else begin
            ev_s1_reg <= event_input_pin;
            ev_s2_reg <= ev_s1_reg;
            ev_s3_reg <= ev_s2_reg;
            fs_s1_reg <= low_frequency_clock;
            fs_s2_reg <= fs_s1_reg;
            fs_s3_reg <= fs_s2_reg;
        end
    end

    assign ev_fall = ev_s3_reg & ~ev_s2_reg;
    assign fs_rise = fs_s2_reg & ~fs_s3_reg;
    assign cascade = ctrl_reg[tc_pair_pkg::CAS_BIT];
    assign presc   = sysm_reg[tc_pair_pkg::PRESC_BIT];
    assign slow    = sysm_reg[tc_pair_pkg::SLOW_BIT];

    // free-running dividers shared by both channels
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pre_reg    <= '0;
            fs_cnt_reg <= '0;
        end else begin
            pre_reg    <= pre_reg + 11'h001;
            fs_cnt_reg <= fs_rise ? fs_cnt_reg + 4'h1 : fs_cnt_reg;
        end
    end

    // lower channel follows upper run and upper mode when cascaded
    assign run_w[0]    = cascade ? ctrl_reg[tc_pair_pkg::RUN_HI_BIT]
                                 : ctrl_reg[tc_pair_pkg::RUN_LO_BIT];
    assign run_w[1]    = ctrl_reg[tc_pair_pkg::RUN_HI_BIT];
    assign eff_mode[0] = cascade ? mode_reg[1] : mode_reg[0];
    assign eff_mode[1] = mode_reg[1];
    assign tick_w[0]   = sel_tick(eff_mode[0],
                                  cascade ? ev_fall[1] : ev_fall[0],
                                  presc, slow, pre_reg, fs_rise, fs_cnt_reg);
    assign tick_w[1]   = cascade ? carry_w[0]
                       : sel_tick(eff_mode[1], ev_fall[1], presc, slow,
                                  pre_reg, fs_rise, fs_cnt_reg);
    assign m16_w       = &m8_w;
    assign pm16_w      = &pm8_w;
    assign clr_w[0]    = cascade
                       ? run_w[0] && tick_w[0] && m16_w
                         && eff_mode[0][1:0] != tc_pair_pkg::OPM_PWM
                       : run_w[0] && tick_w[0] && m8_w[0]
                         && eff_mode[0][1:0] != tc_pair_pkg::OPM_PWM;
    assign clr_w[1]    = cascade ? clr_w[0]
                       : run_w[1] && tick_w[1] && m8_w[1]
                         && eff_mode[1][1:0] != tc_pair_pkg::OPM_PWM;

    // per-channel registers, counter and output flop
    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [19:0] CMP_A  = i ? tc_pair_pkg::CMP1_OFS
                                           : tc_pair_pkg::CMP0_OFS;
        localparam logic [19:0] PWM_A  = i ? tc_pair_pkg::PWM1_OFS
                                           : tc_pair_pkg::PWM_OUTPUT_PIN_OFS;
        localparam logic [19:0] MODE_A = i ? tc_pair_pkg::MODE1_OFS
                                           : tc_pair_pkg::MODE0_OFS;
        chan_if             cb ();
        logic [7:0]         pwm_act_reg;
        logic [7:0]         cmp_act_reg;
        logic               ff_reg;
        logic               pwm_o_reg;
        logic               ppg_o_reg;
        logic               load_act;
        logic               period_end;
        logic               pmatch;
        logic               tff;
        logic               quiet;
        tc_pair_pkg::opmode_t opm;

        assign cb.tick  = tick_w[i];
        assign cb.run   = run_w[i];
        assign cb.clr   = clr_w[i];
        assign cnt_w[i] = cb.cnt;
        assign carry_w[i] = cb.carry;
        assign cmp_act[i] = cmp_act_reg;
        assign m8_w[i]  = cb.cnt == cmp_act_reg;
        assign pm8_w[i] = cb.cnt == pwm_act_reg;
        assign opm      = tc_pair_pkg::opmode_t'(eff_mode[i][1:0]);
        assign tff      = eff_mode[i][tc_pair_pkg::TFF_BIT];
        // stopped or unbuffered: new values act at once
        assign load_act = !eff_mode[i][tc_pair_pkg::DBE_BIT]
                          || !run_w[i] || clr_w[i];
        assign period_end = (opm == tc_pair_pkg::OPM_PWM) ? carry_w[i]
                                                          : clr_w[i];
        assign pmatch   = (cascade && i == 1)
                          ? run_w[0] && tick_w[0] && pm16_w
                          : run_w[i] && tick_w[i] && pm8_w[i];
        assign quiet    = (cascade && i == 0)
                          || opm == tc_pair_pkg::OPM_TIMER_A
                          || opm == tc_pair_pkg::OPM_TIMER_B;

        tc_counter u_cnt (
            .clk_sys (clk_sys),
            .rst_n   (rst_n_reg),
            .ch      (cb.chan)
        );

        always_ff @(posedge clk_sys or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
                cmp_reg[i]  <= tc_pair_pkg::VALUE_RST;
                pwm_reg[i]  <= tc_pair_pkg::VALUE_RST;
                mode_reg[i] <= tc_pair_pkg::MODE_RST;
            end else begin
                if (wr_stb && addr == CMP_A) begin
                    cmp_reg[i] <= wdata;
                end
                if (wr_stb && addr == PWM_A) begin
                    pwm_reg[i] <= wdata;
                end
                if (wr_stb && addr == MODE_A && !run_w[i]) begin
                    mode_reg[i] <= wdata;
                end
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
                cmp_act_reg <= tc_pair_pkg::VALUE_RST;
                pwm_act_reg <= tc_pair_pkg::VALUE_RST;
                ff_reg      <= 1'b1;
                pwm_o_reg   <= 1'b1;
                ppg_o_reg   <= 1'b1;
            end else begin
                if (load_act) begin
                    cmp_act_reg <= cmp_reg[i];
                    pwm_act_reg <= pwm_reg[i];
                end
                // preset level restarts each period, inverts on pwm match
                ff_reg    <= (!run_w[i] || period_end) ? tff
                           : pmatch ? ~tff : ff_reg;
                pwm_o_reg <= quiet || opm != tc_pair_pkg::OPM_PWM
                             || ff_reg;
                ppg_o_reg <= quiet || opm != tc_pair_pkg::OPM_PPG
                             || ff_reg;
            end
        end

        assign pwm_output_pin[i]   = pwm_o_reg;
        assign pulse_output_pin[i] = ppg_o_reg;
    end

    // pair control and system mode
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg <= tc_pair_pkg::CTRL_RST;
            sysm_reg <= tc_pair_pkg::SYSM_RST;
        end else begin
            if (wr_stb && addr == tc_pair_pkg::CTRL_OFS) begin
                ctrl_reg <= wdata;
            end
            if (wr_stb && addr == tc_pair_pkg::SYSM_OFS) begin
                sysm_reg <= {6'h00, wdata[1:0]};
            end
        end
    end

    always_comb begin
        case (addr)
            tc_pair_pkg::CMP0_OFS:  rd_val = cmp_reg[0];
            tc_pair_pkg::CMP1_OFS:  rd_val = cmp_reg[1];
            tc_pair_pkg::PWM_OUTPUT_PIN_OFS:  rd_val = pwm_reg[0];
            tc_pair_pkg::PWM1_OFS:  rd_val = pwm_reg[1];
            tc_pair_pkg::MODE0_OFS: rd_val = mode_reg[0];
            tc_pair_pkg::MODE1_OFS: rd_val = mode_reg[1];
            tc_pair_pkg::CTRL_OFS:  rd_val = ctrl_reg;
            tc_pair_pkg::SYSM_OFS:  rd_val = sysm_reg;
            tc_pair_pkg::CNT0_OFS:  rd_val = cnt_w[0];
            tc_pair_pkg::CNT1_OFS:  rd_val = cnt_w[1];
            default:                rd_val = 8'h00;
        endcase
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_stb ? rd_val : 8'h00;
        end
    end

    assign rdata = rdata_reg;

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rst_n_reg);

    sequence s_write_cmp0;
        wr_stb && addr == tc_pair_pkg::CMP0_OFS;
    endsequence
    sequence s_mode0_busy;
        wr_stb && addr == tc_pair_pkg::MODE0_OFS && run_w[0];
    endsequence

    property p_cmp_store;
        logic [7:0] d;
        (s_write_cmp0, d = wdata) |=> (cmp_reg[0] == d);
    endproperty
    a_cmp_store: assert property (p_cmp_store)
        else $error("compare write not stored");

    property p_dbe_hold;
        run_w[1] && !cascade && eff_mode[1][tc_pair_pkg::DBE_BIT]
        && !clr_w[1] |=> $stable(cmp_act[1]);
    endproperty
    a_dbe_hold: assert property (p_dbe_hold)
        else $error("buffered compare changed mid period");

    property p_gear_div;
        !eff_mode[0][tc_pair_pkg::EXT_BIT] && !presc && !slow
        && eff_mode[0][5:3] == 3'h0 && tick_w[0] |-> (&pre_reg);
    endproperty
    a_gear_div: assert property (p_gear_div)
        else $error("gear divide by 2048 tick misplaced");

    property p_slow_gap;
        slow && !eff_mode[0][tc_pair_pkg::EXT_BIT]
        && eff_mode[0][5:3] == 3'h2 |-> !tick_w[0];
    endproperty
    a_slow_gap: assert property (p_slow_gap)
        else $error("invalid slow clock code ticked");

    property p_ext_edge;
        !cascade && eff_mode[0][tc_pair_pkg::EXT_BIT]
        |-> (tick_w[0] == ev_fall[0]);
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("event clock not from pin falling edge");

    property p_mode_lock;
        s_mode0_busy |=> $stable(mode_reg[0]);
    endproperty
    a_mode_lock: assert property (p_mode_lock)
        else $error("mode changed while running");

    property p_timer_high;
        (!cascade && mode_reg[1][1] == 1'b0) [*2]
        |-> pwm_output_pin[1] && pulse_output_pin[1];
    endproperty
    a_timer_high: assert property (p_timer_high)
        else $error("timer mode output not high");

    property p_cascade_high;
        cascade [*2] |-> pwm_output_pin[0] && pulse_output_pin[0];
    endproperty
    a_cascade_high: assert property (p_cascade_high)
        else $error("lower outputs not high in cascade");

    property p_lower_idle;
        cascade && !ctrl_reg[tc_pair_pkg::RUN_HI_BIT] |=> $stable(cnt_w[0]);
    endproperty
    a_lower_idle: assert property (p_lower_idle)
        else $error("lower channel ran without upper run");

    property p_hold_stop;
        !run_w[1] |=> $stable(cnt_w[1]);
    endproperty
    a_hold_stop: assert property (p_hold_stop)
        else $error("counter moved while stopped");

    property p_byte_carry;
        cascade && carry_w[0] && !clr_w[0]
        |=> cnt_w[1] == 8'($past(cnt_w[1]) + 8'h01);
    endproperty
    a_byte_carry: assert property (p_byte_carry)
        else $error("high byte missed low byte carry");

endmodule : tc_pair_top

// file: event_pins.sv
`timescale 1ns/10ps
module event_pins (
    input  wire logic       clk_sys,
    output logic      [1:0] event_input_pin,
    output logic            low_frequency_clock
);
    // slow oscillator runs free, phase unrelated to clk_sys
    initial begin
        low_frequency_clock = 1'h0;
        #7;
        forever #310 low_frequency_clock = ~low_frequency_clock;
    end

    initial event_input_pin = 2'h3;

    // idle high; 3 cycles low and 3 high, above the 2-cycle minimum
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            event_input_pin[ch] <= 1'h0;
            repeat (3) @(posedge clk_sys);
            event_input_pin[ch] <= 1'h1;
            repeat (2) @(posedge clk_sys);
        end
    endtask : pulse
endmodule : event_pins

// file: tc_pair_top_tb.sv
`timescale 1ns/10ps
module tc_pair_top_tb;
    logic        clk_sys;
    logic        nrst;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  rdata;
    logic [1:0]  event_input_pin;
    logic        low_frequency_clock;
    logic [1:0]  pwm_output_pin;
    logic [1:0]  pulse_output_pin;
    logic [7:0]  exp_q[$];
    logic        rd_seen;
    logic [7:0]  rnd;
    logic [7:0]  rst_tab [11];
    int          miscompares;
    int          samples_checked;
    int          cycles;
    int          n;

    tc_pair_top uut (
        .clk_sys             (clk_sys),
        .nrst                (nrst),
        .addr                (addr),
        .wdata               (wdata),
        .wr_stb              (wr_stb),
        .rd_stb              (rd_stb),
        .rdata               (rdata),
        .event_input_pin     (event_input_pin),
        .low_frequency_clock (low_frequency_clock),
        .pwm_output_pin      (pwm_output_pin),
        .pulse_output_pin    (pulse_output_pin)
    );

    event_pins far_side (
        .clk_sys             (clk_sys),
        .event_input_pin     (event_input_pin),
        .low_frequency_clock (low_frequency_clock)
    );

    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // rdata stands only in the cycle after the strobe
    always @(posedge clk_sys) rd_seen <= rd_stb;
    always @(negedge clk_sys) begin
        if (rd_seen === 1'h1 && exp_q.size() > 0) begin
            cmp(rdata, exp_q.pop_front());
        end
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // a gap cycle between strobes keeps each signal to one write per step
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'h1;
        @(posedge clk_sys);
        wr_stb <= 1'h0;
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        addr   <= a;
        rd_stb <= 1'h1;
        @(posedge clk_sys);
        rd_stb <= 1'h0;
    endtask : rd

    task automatic check_pins();
        @(negedge clk_sys);
        cmp({4'h0, pwm_output_pin, pulse_output_pin}, 8'h0F);
    endtask : check_pins

    // internal reset trails nrst by two flops, so wait 3 edges
    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'h0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (3) @(posedge clk_sys);
    endtask : do_reset

    // 64 run edges: every divider tap up to divide by 64 lands a whole number of times
    task automatic run_ch1(input logic [7:0] m, input logic [7:0] e);
        wr(20'h0002B, m);
        wr(20'h0002C, 8'h02);
        repeat (62) @(posedge clk_sys);
        wr(20'h0002C, 8'h00);
        rd(20'h0002F, e);
    endtask : run_ch1

    initial begin
        nrst = 1'h0;
        addr = 20'h00000;
        wdata = 8'h00;
        wr_stb = 1'h0;
        rd_stb = 1'h0;
        rd_seen = 1'h0;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        rst_tab = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC0, 8'hC0,
                    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(32'h3397));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'h1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 11; i++) begin
            rd(20'h00026 + 20'(i), rst_tab[i]);
        end
        check_pins();
        for (int i = 0; i < 4; i++) begin
            rnd = 8'($urandom);
            wr(20'h00026 + 20'(i), rnd);
            rd(20'h00026 + 20'(i), rnd);
        end
        for (int op = 0; op < 4; op++) begin
            wr(20'h0002A, 8'hC0 | 8'(op));
            rd(20'h0002A, 8'hC0 | 8'(op));
        end
        do_reset();
        // slow mode: code 010 is not a valid source, so no ticks
        wr(20'h0002D, 8'h02);
        wr(20'h0002A, 8'hD0);
        wr(20'h0002C, 8'h01);
        repeat (64) @(posedge clk_sys);
        rd(20'h0002E, 8'h00);
        wr(20'h0002C, 8'h00);
        wr(20'h0002D, 8'h00);
        wr(20'h0002A, 8'hFC);
        wr(20'h0002C, 8'h01);
        n = 1 + ($urandom % 8);
        far_side.pulse(0, n);
        repeat (8) @(posedge clk_sys);
        rd(20'h0002E, 8'(n));
        check_pins();
        wr(20'h0002A, 8'h80);
        rd(20'h0002A, 8'hFC);
        wr(20'h0002C, 8'h00);
        far_side.pulse(0, 3);
        repeat (8) @(posedge clk_sys);
        rd(20'h0002E, 8'(n));
        // gear /16 over 64 edges gives 4
        run_ch1(8'hE0, 8'h04);
        // compare 09: from 4, period 10 leaves 8 after 64 ticks
        wr(20'h00027, 8'h09);
        run_ch1(8'hF8, 8'h08);
        // pwm mode ignores the compare clear: 8 + 64
        run_ch1(8'hFA, 8'h48);
        do_reset();
        // lower mode would tick every cycle if it were still obeyed
        wr(20'h0002A, 8'hF8);
        wr(20'h0002B, 8'hFC);
        wr(20'h0002C, 8'h05);
        far_side.pulse(1, 3);
        repeat (8) @(posedge clk_sys);
        rd(20'h0002E, 8'h00);
        check_pins();
        wr(20'h0002C, 8'h06);
        far_side.pulse(1, 258);
        repeat (8) @(posedge clk_sys);
        rd(20'h0002E, 8'h02);
        rd(20'h0002F, 8'h01);
        repeat (3) @(posedge clk_sys);
        print_verdict();
    end
endmodule : tc_pair_top_tb
